// file: hdl/cise_core.sv
// Function
// - allow-interrupts sets enable bit, one cycle
// - indexed branch loads pointer and accumulator, two cycles
// - increment register to accumulator or register, zero flag
// - increment-skip writes result to selected destination
// - zero result discards fetched instruction, two cycles
// - software interrupt pushes pc+1, jumps to 001
// - OR accumulator with register, selected destination, zero
`timescale 1ns/10ps
`default_nettype none
module cise_core
   import cise_pkg::*;
(
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // instruction issue
   input wire logic i_valid,
   input wire cise_instr_s i_instr,
   output logic o_ready,
   // core state inputs
   input wire logic [7:0] i_reg_rdata,
   input wire logic [2:0] i_table_high_pointer,
   input wire logic [7:0] i_acc_load,
   input wire logic i_acc_load_en,
   // register file side
   output logic [6:0] o_reg_raddr,
   output cise_wr_s o_reg_wr,
   // stack push
   output logic o_push,
   output logic [10:0] o_push_data,
   // architectural state
   output logic [7:0] o_accumulator,
   output logic o_zero_flag,
   output logic o_global_irq_allow,
   output logic [10:0] o_pc,
   output logic o_discard
);
   typedef enum logic [1:0]
   {
      CISE_S_RUN = 2'b01,
      CISE_S_WAIT = 2'b10
   } cise_state_e;

   cise_state_e state_r;
   logic [1:0] wait_r;
   logic [7:0] alu_res;
   logic alu_zero;
   logic take;
   logic is_inc;
   logic is_or;

   assign take = i_valid && (state_r == CISE_S_RUN);
   assign o_ready = (state_r == CISE_S_RUN);
   assign o_reg_raddr = i_instr.addr;
   assign is_inc = (i_instr.op == CISE_OP_REG_INCREMENT) ||
                   (i_instr.op == CISE_OP_INCREMENT_SKIP_ZERO);
   assign is_or = (i_instr.op == CISE_OP_OR_ACC_REG);

   cise_alu u_alu
   (
      .i_acc(o_accumulator),
      .i_reg(i_reg_rdata),
      .i_sel_or(is_or),
      .o_res(alu_res),
      .o_zero(alu_zero)
   );

   // multi-cycle sequencing; extra cycles hold off the next issue
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         state_r <= CISE_S_RUN;
         wait_r <= 2'h0;
      end
      else
      begin
         unique case (state_r)
            CISE_S_RUN:
            begin
               if (take && i_instr.op == CISE_OP_BRANCH_INDEXED)
               begin
                  state_r <= CISE_S_WAIT;
                  wait_r <= CISE_BR_CYC - CISE_ONE_CYC;
               end
               else if (take && i_instr.op == CISE_OP_SWI)
               begin
                  state_r <= CISE_S_WAIT;
                  wait_r <= CISE_SWI_CYC - CISE_ONE_CYC;
               end
               else if (take && alu_zero &&
                        i_instr.op == CISE_OP_INCREMENT_SKIP_ZERO)
               begin
                  state_r <= CISE_S_WAIT;
                  wait_r <= CISE_SKIP_CYC - CISE_ONE_CYC;
               end
            end
            CISE_S_WAIT:
            begin
               wait_r <= wait_r - CISE_ONE_CYC;
               if (wait_r == CISE_ONE_CYC)
                  state_r <= CISE_S_RUN;
            end
         endcase
      end
   end

   // discard pulse during the skip cycle (acts as a nop)
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
         o_discard <= 1'b0;
      else
         o_discard <= take && alu_zero &&
                      i_instr.op == CISE_OP_INCREMENT_SKIP_ZERO;
   end

   // global interrupt enable; no other flag is touched
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
         o_global_irq_allow <= 1'b0;
      else if (take && i_instr.op == CISE_OP_IRQ_ALLOW)
         o_global_irq_allow <= 1'b1;
   end

   // accumulator: own results win over external loads
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
         o_accumulator <= CISE_ZERO;
      else if (take && (is_inc || is_or) && !i_instr.dest_reg)
         o_accumulator <= alu_res;
      else if (i_acc_load_en)
         o_accumulator <= i_acc_load;
   end

   // zero flag from increment and OR only
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
         o_zero_flag <= 1'b0;
      else if (take && (is_inc || is_or))
         o_zero_flag <= alu_zero;
   end

   // register writeback when destination select is 1
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
         o_reg_wr <= '0;
      else
      begin
         o_reg_wr.en <= take && (is_inc || is_or) && i_instr.dest_reg;
         o_reg_wr.addr <= i_instr.addr;
         o_reg_wr.data <= alu_res;
      end
   end

   // program counter and return push
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         o_pc <= CISE_PC_RST;
         o_push <= 1'b0;
         o_push_data <= CISE_PC_RST;
      end
      else
      begin
         o_push <= take && i_instr.op == CISE_OP_SWI;
         o_push_data <= o_pc + 11'h001;
         if (take && i_instr.op == CISE_OP_BRANCH_INDEXED)
            o_pc <= {i_table_high_pointer, o_accumulator};
         else if (take && i_instr.op == CISE_OP_SWI)
            o_pc <= CISE_SWI_VEC;
         else if (take)
            o_pc <= o_pc + 11'h001;
         // the dropped slot still uses an address, so the next issue
         // lands past the skipped instruction instead of repeating it
         else if (o_discard)
            o_pc <= o_pc + 11'h001;
      end
   end

   // assertions
   a_irq_allow_set: assert property (
      @(posedge i_clk) disable iff (i_rst)
      take && i_instr.op == CISE_OP_IRQ_ALLOW |=> o_global_irq_allow)
      else $error("irq allow not set");

   a_branch_target: assert property (
      @(posedge i_clk) disable iff (i_rst)
      take && i_instr.op == CISE_OP_BRANCH_INDEXED |=>
      o_pc == {$past(i_table_high_pointer), $past(o_accumulator)}
      ##0 !o_ready ##1 o_ready)
      else $error("indexed branch wrong");

   a_inc_acc: assert property (
      @(posedge i_clk) disable iff (i_rst)
      take && i_instr.op == CISE_OP_REG_INCREMENT && !i_instr.dest_reg |=>
      o_accumulator == 8'($past(i_reg_rdata) + 8'h01))
      else $error("increment to accumulator wrong");

   a_incskip_reg: assert property (
      @(posedge i_clk) disable iff (i_rst)
      take && i_instr.op == CISE_OP_INCREMENT_SKIP_ZERO && i_instr.dest_reg
      |=> o_reg_wr.en && o_reg_wr.data == 8'($past(i_reg_rdata) + 8'h01))
      else $error("increment skip writeback wrong");

   sequence s_skip_cycle;
      o_discard && !o_ready ##1 o_ready;
   endsequence
   a_skip_discard: assert property (
      @(posedge i_clk) disable iff (i_rst)
      take && i_instr.op == CISE_OP_INCREMENT_SKIP_ZERO &&
      i_reg_rdata == 8'hFF |=> s_skip_cycle)
      else $error("skip not taken");

   a_skip_pc_step: assert property (
      @(posedge i_clk) disable iff (i_rst)
      take && i_instr.op == CISE_OP_INCREMENT_SKIP_ZERO &&
      i_reg_rdata == 8'hFF |=> ##1 o_pc == 11'($past(o_pc, 2) + 11'h002))
      else $error("skip did not step over");

   a_swi_seq: assert property (
      @(posedge i_clk) disable iff (i_rst)
      take && i_instr.op == CISE_OP_SWI |=>
      o_push && o_push_data == 11'($past(o_pc) + 11'h001) &&
      o_pc == 11'h001 ##0 !o_ready [*2] ##1 o_ready)
      else $error("software interrupt wrong");

   a_or_result: assert property (
      @(posedge i_clk) disable iff (i_rst)
      take && is_or && !i_instr.dest_reg |=>
      o_accumulator == ($past(o_accumulator) | $past(i_reg_rdata)) &&
      o_zero_flag == (o_accumulator == 8'h00))
      else $error("or result wrong");

   a_inc_wrap: assert property (
      @(posedge i_clk) disable iff (i_rst)
      take && is_inc && i_reg_rdata == 8'hFF |=> o_zero_flag)
      else $error("wrap did not set zero");
endmodule : cise_core
`default_nettype wire

// file: hdl/cise_pkg.sv
package cise_pkg;
   localparam int CISE_DW = 8;
   localparam int CISE_PCW = 11;
   localparam int CISE_AW = 7;
   localparam int CISE_TBW = 3;
   localparam logic [10:0] CISE_SWI_VEC = 11'h001;
   localparam logic [10:0] CISE_PC_RST = 11'h000;
   localparam logic [7:0] CISE_ONE = 8'h01;
   localparam logic [7:0] CISE_ZERO = 8'h00;
   localparam logic [1:0] CISE_BR_CYC = 2'h2;
   localparam logic [1:0] CISE_SWI_CYC = 2'h3;
   localparam logic [1:0] CISE_SKIP_CYC = 2'h2;
   localparam logic [1:0] CISE_ONE_CYC = 2'h1;

   // opcode selector from the decoder outside
   typedef enum logic [2:0]
   {
      CISE_OP_NONE = 3'h0,
      CISE_OP_IRQ_ALLOW = 3'h1,
      CISE_OP_BRANCH_INDEXED = 3'h2,
      CISE_OP_REG_INCREMENT = 3'h3,
      CISE_OP_INCREMENT_SKIP_ZERO = 3'h4,
      CISE_OP_SWI = 3'h5,
      CISE_OP_OR_ACC_REG = 3'h6
   } cise_op_e;

   // one decoded instruction
   typedef struct packed
   {
      cise_op_e op;
      logic [6:0] addr;
      logic dest_reg;
   } cise_instr_s;

   // register file write
   typedef struct packed
   {
      logic en;
      logic [6:0] addr;
      logic [7:0] data;
   } cise_wr_s;
endpackage : cise_pkg

// file: hdl/cise_alu.sv
`timescale 1ns/10ps
`default_nettype none
// increment and OR datapath, wraps modulo 256
module cise_alu
   import cise_pkg::*;
(
   // operands
   input wire logic [7:0] i_acc,
   input wire logic [7:0] i_reg,
   input wire logic i_sel_or,
   // result
   output logic [7:0] o_res,
   output logic o_zero
);
   // 8-bit add drops carry so 0xFF becomes zero
   always_comb
   begin
      if (i_sel_or)
         o_res = i_acc | i_reg;
      else
         o_res = i_reg + CISE_ONE;
      o_zero = (o_res == CISE_ZERO);
   end
endmodule : cise_alu
`default_nettype wire

// file: sim/cise_core_bench.sv
`timescale 1ns/10ps
`default_nettype none
module cise_core_bench
   import cise_pkg::*;
;
   logic i_clk, i_rst, i_valid, o_ready, i_acc_load_en, o_push;
   logic o_zero_flag, o_global_irq_allow, o_discard, z_m, gie_m, pc_ok;
   cise_instr_s i_instr;
   cise_wr_s o_reg_wr;
   logic [7:0] i_reg_rdata, i_acc_load, o_accumulator, acc_m;
   logic [6:0] o_reg_raddr;
   logic [2:0] i_table_high_pointer;
   logic [10:0] o_push_data, o_pc, pc_m;
   logic [31:0] seed;
   int error_cnt, checks, cyc;

   cise_core u_cise_core (.i_clk(i_clk), .i_rst(i_rst),
      .i_valid(i_valid), .i_instr(i_instr), .o_ready(o_ready),
      .i_reg_rdata(i_reg_rdata),
      .i_table_high_pointer(i_table_high_pointer),
      .i_acc_load(i_acc_load), .i_acc_load_en(i_acc_load_en),
      .o_reg_raddr(o_reg_raddr), .o_reg_wr(o_reg_wr), .o_push(o_push),
      .o_push_data(o_push_data), .o_accumulator(o_accumulator),
      .o_zero_flag(o_zero_flag), .o_global_irq_allow(o_global_irq_allow),
      .o_pc(o_pc), .o_discard(o_discard));

   // free-running 50 MHz clock
   initial
   begin
      i_clk = 1'b0;
      forever #10 i_clk = ~i_clk;
   end

   // hang guard, far above the few hundred cycles the run needs
   always @(posedge i_clk)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         error_cnt++;
         $display("CHECK FAILED at %0t: timeout", $time);
         close_out();
      end
   end

   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      s = s ^ (s << 5);
      return s;
   endfunction : xs

   // expected datapath result, 8-bit so increments wrap
   function automatic logic [7:0] res_f(input cise_op_e op,
      input logic [7:0] a, input logic [7:0] r);
      return (op == CISE_OP_OR_ACC_REG) ? (a | r) : r + CISE_ONE;
   endfunction : res_f

   task automatic cmp(input logic [15:0] got, input logic [15:0] exp,
      input string what);
      checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what,
            got, exp);
      end
   endtask : cmp

   // busy window; a request offered meanwhile must be ignored
   // valid stays up from the issue, so only the instruction changes
   task automatic stall(input int n);
      if (n > 0)
         i_instr = '{CISE_OP_REG_INCREMENT, 7'h01, 1'b1};
      repeat (n)
      begin
         cmp(o_ready, 1'b0, "busy");
         @(negedge i_clk);
         cmp(o_reg_wr.en, 1'b0, "refused");
      end
      cmp(o_ready, 1'b1, "ready");
   endtask : stall

   // load enable is left up; the next issue drops it
   task automatic load(input logic [7:0] v);
      i_valid = 1'b0;
      i_acc_load = v;
      i_acc_load_en = 1'b1;
      @(negedge i_clk);
      acc_m = v;
      cmp(o_accumulator, acc_m, "load");
   endtask : load

   task automatic issue(input cise_op_e op, input logic [6:0] a,
      input logic d, input logic [7:0] rd);
      logic [7:0] res;
      logic arith, skip;
      int busy;
      i_acc_load_en = 1'b0;
      i_valid = 1'b1;
      i_instr = '{op, a, d};
      i_reg_rdata = rd;
      res = res_f(op, acc_m, rd);
      arith = op inside {CISE_OP_REG_INCREMENT, CISE_OP_OR_ACC_REG,
         CISE_OP_INCREMENT_SKIP_ZERO};
      skip = (op == CISE_OP_INCREMENT_SKIP_ZERO) && (res == CISE_ZERO);
      busy = (op == CISE_OP_SWI) ? 2 :
         int'(skip || op == CISE_OP_BRANCH_INDEXED);
      #1 cmp(o_reg_raddr, a, "raddr");
      @(negedge i_clk);
      cmp(o_push, op == CISE_OP_SWI, "push");
      cmp(o_discard, skip, "discard");
      cmp(o_reg_wr.en, arith && d, "wr en");
      if (op == CISE_OP_IRQ_ALLOW)
         gie_m = 1'b1;
      if (op == CISE_OP_SWI && pc_ok)
         cmp(o_push_data, 11'(pc_m + 11'h001), "ret");
      pc_m = pc_m + 11'h001;
      if (arith)
      begin
         z_m = (res == CISE_ZERO);
         if (d)
            cmp({o_reg_wr.addr, o_reg_wr.data}, {a, res}, "wr");
         else
            acc_m = res;
      end
      cmp(o_accumulator, acc_m, "acc");
      cmp(o_zero_flag, z_m, "zero");
      cmp(o_global_irq_allow, gie_m, "irq");
      if (op == CISE_OP_BRANCH_INDEXED)
      begin
         pc_m = {i_table_high_pointer, acc_m};
         pc_ok = 1'b1;
      end
      if (op == CISE_OP_SWI)
      begin
         pc_m = CISE_SWI_VEC;
         pc_ok = 1'b1;
      end
      if (pc_ok)
         cmp(o_pc, pc_m, "pc");
      stall(busy);
      // the dropped slot moves the program counter on by one more
      if (skip)
      begin
         pc_m = pc_m + 11'h001;
         cmp(o_pc, pc_m, "skip pc");
      end
   endtask : issue

   task automatic close_out();
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : close_out

   initial
   begin
      {i_valid, i_acc_load_en, i_instr, i_reg_rdata, i_acc_load} = '0;
      {acc_m, pc_m, z_m, gie_m, i_table_high_pointer} = '0;
      {error_cnt, checks} = '0;
      pc_ok = 1'b1;
      seed = 32'h0000B9A9;
      i_rst = 1'b1;
      repeat (4) @(negedge i_clk);
      i_rst = 1'b0;
      cmp({o_pc, o_ready, o_global_irq_allow}, 13'h0002, "reset");
      $display("test reset done");
      load(8'h34);
      i_table_high_pointer = 3'h2;
      issue(CISE_OP_BRANCH_INDEXED, 7'h00, 1'b0, 8'h00);
      issue(CISE_OP_SWI, 7'h00, 1'b0, 8'h00);
      issue(CISE_OP_IRQ_ALLOW, 7'h00, 1'b0, 8'h00);
      issue(CISE_OP_REG_INCREMENT, 7'h7F, 1'b1, 8'hFF);
      issue(CISE_OP_INCREMENT_SKIP_ZERO, 7'h00, 1'b1, 8'hFF);
      issue(CISE_OP_INCREMENT_SKIP_ZERO, 7'h05, 1'b0, 8'hFE);
      load(8'hAA);
      issue(CISE_OP_OR_ACC_REG, 7'h11, 1'b1, 8'h50);
      $display("test directed done");
      repeat (80)
      begin
         seed = xs(seed);
         i_table_high_pointer = seed[18:16];
         if (seed[2:0] == 3'h0 || seed[2:0] == 3'h7)
            load(seed[15:8]);
         else
            issue(cise_op_e'(seed[2:0]), seed[25:19], seed[26],
               seed[27] ? 8'hFF : seed[15:8]);
      end
      $display("test random done");
      close_out();
   end
endmodule : cise_core_bench
`default_nettype wire
